// ===== common/eeprom_pkg.sv
package eeprom_pkg;

    ////////////////////////////////////////////////////////////////////////
    // array geometry
    localparam int ADDR_W = 9;        // nine-bit array address
    localparam int DATA_W = 8;        // byte-wide storage
    localparam int MEM_DEPTH = 512;   // bytes in the array
    localparam int PAGE_BITS = 4;     // low address bits that wrap in a page
    localparam int FIFO_DEPTH = 32;   // words of write staging

    ////////////////////////////////////////////////////////////////////////
    // slave address field positions
    localparam int DEV_RW_BIT = 0;    // one selects read
    localparam int DEV_BLK_BIT = 1;   // ninth array address bit
    localparam int DEV_CS_LSB = 2;    // two chip-select bits
    localparam int DEV_TYPE_LSB = 4;  // four-bit device-type field

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [8:0] RST_ADDR = 9'h000;
    localparam logic [3:0] RST_LINES = 4'hf;  // bus idles high

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int WRITE_TIME_US = 5000;      // self-timed write cycle
    localparam int CLK_FREQ_MHZ = 50;
    localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_FREQ_MHZ;

    ////////////////////////////////////////////////////////////////////////
    // carriers and enumerations
    typedef struct packed {
        logic [8:0] addr;   // target location
        logic [7:0] data;   // byte to store
    } wr_entry_t;

    typedef struct packed {
        logic sclLevel;       // synchronised clock level
        logic sdaLevel;       // synchronised data level
        logic sclRise;        // clock rose
        logic sclFall;        // clock fell
        logic start;          // data fell while clock high
        logic stop;           // data rose while clock high
        logic [1:0] chipSel;  // {high pin, low pin}
    } line_ev_t;

    typedef enum logic [2:0] {ST_IDLE, ST_RECV, ST_ACK, ST_SEND, ST_RACK} bus_state_t;
    typedef enum logic [1:0] {BK_DEV, BK_WORD, BK_DATA} byte_kind_t;

endpackage : eeprom_pkg

// ===== rtl/line_sampler.sv
`timescale 1ns/1ps
module line_sampler (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // raw pins
    input wire logic scl,
    input wire logic sdaIn,
    input wire logic [1:0] chipSel,
    // sampled events
    output eeprom_pkg::line_ev_t ev
);

    logic [3:0] syncA;   // first stage, read only by syncB
    logic [3:0] syncB;   // second stage
    logic [3:0] prev;    // previous settled sample

    ////////////////////////////////////////////////////////////////////////
    // two-flop synchroniser for all pins
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            syncA <= eeprom_pkg::RST_LINES;
            syncB <= eeprom_pkg::RST_LINES;
            prev <= eeprom_pkg::RST_LINES;
        end else begin
            syncA <= {chipSel, sdaIn, scl};
            syncB <= syncA;
            prev <= syncB;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // edge and start/stop detection, registered
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ev <= '0;
        end else begin
            ev.sclLevel <= syncB[0];
            ev.sdaLevel <= syncB[1];
            ev.sclRise <= syncB[0] & ~prev[0];
            ev.sclFall <= ~syncB[0] & prev[0];
            // data moving under a high clock is a frame marker
            ev.start <= syncB[0] & prev[0] & prev[1] & ~syncB[1];
            ev.stop <= syncB[0] & prev[0] & ~prev[1] & syncB[1];
            ev.chipSel <= syncB[3:2];
        end
    end

endmodule : line_sampler

// ===== rtl/sync_fifo.sv
`timescale 1ns/1ps
module sync_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
            $error("fifo depth must be a power of two");
        end
    endgenerate

    logic [WIDTH-1:0] store [0:DEPTH-1];  // entry storage
    logic [PTR_W-1:0] wrPtr;
    logic [PTR_W-1:0] rdPtr;
    logic [PTR_W:0] count;                // honest occupancy
    logic doPush;
    logic doPop;

    assign inReady = (count != (PTR_W+1)'(DEPTH));
    assign outValid = (count != '0);
    assign doPush = inValid & inReady;
    assign doPop = outValid & outReady;
    assign outData = store[rdPtr];

    ////////////////////////////////////////////////////////////////////////
    // storage, no reset needed
    always_ff @(posedge sys_clk) begin
        if (doPush) begin
            store[wrPtr] <= inData;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pointers and count
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (doPush) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (doPop) begin
                rdPtr <= rdPtr + 1'b1;
            end
            count <= count + (PTR_W+1)'(doPush) - (PTR_W+1)'(doPop);
        end
    end

endmodule : sync_fifo

// ===== rtl/eeprom_serial_slave.sv
`timescale 1ns/1ps
module eeprom_serial_slave #(
    parameter logic [3:0] DEV_TYPE = 4'h6,  // arbitrary type code
    parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES,
    parameter int FIFO_DEPTH = eeprom_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // two-wire bus
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // address straps
    input wire logic chipSelectLowPin,
    input wire logic chipSelectHighPin,
    input wire logic unusedAddressPin,
    // status
    output logic writeBusy
);

    localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
    localparam int ENTRY_W = $bits(eeprom_pkg::wr_entry_t);
    default clocking chkClk @(posedge sys_clk); endclocking  // checks sample the system clock
    default disable iff (rst);  // and sleep through reset

    generate
        if (WRITE_CYCLES < 1) begin : g_bad_wait
            $error("write cycle count must be at least one");
        end
        if (FIFO_DEPTH < 16) begin : g_bad_depth
            $error("fifo must hold a full page");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // declarations
    eeprom_pkg::line_ev_t ev;            // sampled bus events
    eeprom_pkg::bus_state_t state;       // protocol position
    eeprom_pkg::byte_kind_t kind;        // meaning of current byte
    logic [3:0] bitCnt;                  // bits moved in this byte
    logic gotByte;                       // eight bits received
    logic [7:0] shiftReg;                // serial byte
    logic readMode;                      // operation selected
    logic blockBit;                      // ninth address bit
    logic [8:0] addr;                    // address counter
    logic acked;                         // master ack sample
    logic pendingWrite;                  // data staged for commit
    logic busy;                          // internal write running
    logic [CNT_W-1:0] waitCnt;           // write cycle timer
    logic [7:0] mem [0:eeprom_pkg::MEM_DEPTH-1];  // the array
    logic devMatch;
    logic byteDone;
    logic ackNow;
    logic loadRead;
    logic [7:0] readByte;
    logic pushValid;
    logic pushReady;
    eeprom_pkg::wr_entry_t pushData;
    logic popValid;
    logic popReady;
    eeprom_pkg::wr_entry_t popData;

    ////////////////////////////////////////////////////////////////////////
    // pin sampling
    line_sampler u_sampler (
        .sys_clk(sys_clk),
        .rst(rst),
        .scl(scl),
        .sdaIn(sdaIn),
        .chipSel({chipSelectHighPin, chipSelectLowPin}),
        .ev(ev)
    );

    // the unused strap is only required to be tied low; no logic needs it
    assign sdaOut = 1'b0;     // open drain: only ever pulls low
    assign writeBusy = busy;

    ////////////////////////////////////////////////////////////////////////
    // decode terms
    // compare type field and straps against this device
    assign devMatch = (shiftReg[eeprom_pkg::DEV_TYPE_LSB +: 4] == DEV_TYPE)
                    && (shiftReg[eeprom_pkg::DEV_CS_LSB +: 2] == ev.chipSel);
    // a byte is judged on the fall that closes its eighth clock
    assign byteDone = (state == eeprom_pkg::ST_RECV) && gotByte && ev.sclFall;
    assign pushValid = byteDone && (kind == eeprom_pkg::BK_DATA);
    // a full staging fifo refuses the byte by withholding ack
    assign ackNow = byteDone && ((kind == eeprom_pkg::BK_DEV) ? devMatch :
                    (kind == eeprom_pkg::BK_WORD) ? 1'b1 : pushReady);
    assign readByte = mem[addr];
    // a read byte is fetched after the address ack or an acked byte
    assign loadRead = ev.sclFall && !busy && !ev.start && !ev.stop &&
                      (((state == eeprom_pkg::ST_ACK) && readMode &&
                        (kind == eeprom_pkg::BK_DEV)) ||
                       ((state == eeprom_pkg::ST_RACK) && acked));
    assign pushData.addr = addr;
    assign pushData.data = shiftReg;
    assign popReady = busy;   // drain only inside the write cycle

    ////////////////////////////////////////////////////////////////////////
    // protocol state
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= eeprom_pkg::ST_IDLE;
            kind <= eeprom_pkg::BK_DEV;
        end else if (busy) begin
            // inputs disabled while committing
            state <= eeprom_pkg::ST_IDLE;
        end else if (ev.stop) begin
            state <= eeprom_pkg::ST_IDLE;
        end else if (ev.start) begin
            // repeated start is also accepted here
            state <= eeprom_pkg::ST_RECV;
            kind <= eeprom_pkg::BK_DEV;
        end else begin
            case (state)
                eeprom_pkg::ST_RECV: begin
                    if (byteDone) begin
                        state <= ackNow ? eeprom_pkg::ST_ACK : eeprom_pkg::ST_IDLE;
                    end
                end
                eeprom_pkg::ST_ACK: begin
                    if (ev.sclFall) begin
                        if (readMode && kind == eeprom_pkg::BK_DEV) begin
                            state <= eeprom_pkg::ST_SEND;
                        end else begin
                            state <= eeprom_pkg::ST_RECV;
                            // data bytes keep coming until the stop
                            kind <= (kind == eeprom_pkg::BK_DEV) ? eeprom_pkg::BK_WORD :
                                    eeprom_pkg::BK_DATA;
                        end
                    end
                end
                eeprom_pkg::ST_SEND: begin
                    if (ev.sclFall && bitCnt == 4'h8) begin
                        state <= eeprom_pkg::ST_RACK;
                    end
                end
                eeprom_pkg::ST_RACK: begin
                    if (ev.sclFall) begin
                        // no ack: quit sending, wait for the stop
                        state <= acked ? eeprom_pkg::ST_SEND : eeprom_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= eeprom_pkg::ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bit shifting and counting
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bitCnt <= 4'h0;
            gotByte <= 1'b0;
            shiftReg <= 8'h00;
        end else if (busy || ev.start || ev.stop) begin
            bitCnt <= 4'h0;
            gotByte <= 1'b0;
        end else if (loadRead) begin
            shiftReg <= readByte;
            bitCnt <= 4'h1;
        end else begin
            case (state)
                eeprom_pkg::ST_RECV: begin
                    if (ev.sclRise && !gotByte) begin
                        // sample on the rising edge, msb first
                        shiftReg <= {shiftReg[6:0], ev.sdaLevel};
                        bitCnt <= bitCnt + 4'h1;
                        gotByte <= (bitCnt == 4'h7);
                    end
                end
                eeprom_pkg::ST_ACK: begin
                    bitCnt <= 4'h0;
                    gotByte <= 1'b0;
                end
                eeprom_pkg::ST_SEND: begin
                    if (ev.sclFall && bitCnt != 4'h8) begin
                        shiftReg <= {shiftReg[6:0], 1'b0};
                        bitCnt <= bitCnt + 4'h1;
                    end
                end
                default: begin
                    bitCnt <= bitCnt;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data line drive; every change except a release on start, stop or busy lands on a low clock
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sdaOe <= 1'b0;
        end else if (busy || ev.start || ev.stop) begin
            sdaOe <= 1'b0;
        end else if (ackNow) begin
            sdaOe <= 1'b1;
        end else if (loadRead) begin
            sdaOe <= ~readByte[7];
        end else if (ev.sclFall) begin
            // only a sending byte drives; after the eighth bit the ack slot is released
            sdaOe <= (state == eeprom_pkg::ST_SEND) && (bitCnt != 4'h8)
                     && !shiftReg[6];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // master acknowledge sampling and operation selection
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            acked <= 1'b0;
            readMode <= 1'b0;
            blockBit <= 1'b0;
        end else begin
            if (state == eeprom_pkg::ST_RACK && ev.sclRise) begin
                acked <= ~ev.sdaLevel;
            end
            if (ackNow && kind == eeprom_pkg::BK_DEV) begin
                readMode <= shiftReg[eeprom_pkg::DEV_RW_BIT];
                blockBit <= shiftReg[eeprom_pkg::DEV_BLK_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // address counter
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            addr <= eeprom_pkg::RST_ADDR;
        end else if (ackNow && kind == eeprom_pkg::BK_WORD) begin
            addr <= {blockBit, shiftReg};
        end else if (pushValid && pushReady) begin
            // the page bits wrap, the upper five stay put
            addr <= {addr[8:4], addr[3:0] + 4'h1};
        end else if (loadRead) begin
            addr <= addr + 9'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write staging; overwrites inside a page land in order
    sync_fifo #(
        .WIDTH(ENTRY_W),
        .DEPTH(FIFO_DEPTH)
    ) u_stage (
        .sys_clk(sys_clk),
        .rst(rst),
        .inValid(pushValid),
        .inReady(pushReady),
        .inData(pushData),
        .outValid(popValid),
        .outReady(popReady),
        .outData(popData)
    );

    ////////////////////////////////////////////////////////////////////////
    // self-timed write cycle, started by the stop
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            waitCnt <= '0;
            pendingWrite <= 1'b0;
        end else if (!busy) begin
            if (ev.stop && (pendingWrite || (pushValid && pushReady))) begin
                busy <= 1'b1;
                waitCnt <= CNT_W'(WRITE_CYCLES - 1);
                pendingWrite <= 1'b0;
            end else if (pushValid && pushReady) begin
                pendingWrite <= 1'b1;  // kept across a repeated start
            end
        end else if (waitCnt != '0) begin
            waitCnt <= waitCnt - 1'b1;
        end else if (!popValid) begin
            busy <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // array write port fed from staging
    always_ff @(posedge sys_clk) begin
        if (popValid && popReady) begin
            mem[popData.addr] <= popData.data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_devJudge;
        (state == eeprom_pkg::ST_RECV) && (kind == eeprom_pkg::BK_DEV) && byteDone;
    endsequence
    sequence s_nackFall;
        (state == eeprom_pkg::ST_RACK) && ev.sclFall && !acked && !ev.stop && !ev.start;
    endsequence
    property p_ack_drive;
        (state == eeprom_pkg::ST_ACK) |-> sdaOe;
    endproperty
    a_ack_drive: assert property (p_ack_drive) else $error("ack slot not driven");
    property p_idle_quiet;
        (state == eeprom_pkg::ST_IDLE) && $past(state == eeprom_pkg::ST_IDLE) |-> !sdaOe;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("drive while idle");
    property p_low_change;
        $changed(sdaOe) |-> !$past(ev.sclLevel) || $past(ev.start || ev.stop || busy);
    endproperty
    a_low_change: assert property (p_low_change) else $error("data moved under clock");
    property p_stop_idle;
        ev.stop |=> (state == eeprom_pkg::ST_IDLE) && !sdaOe;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop not honoured");
    property p_busy_deaf;
        busy |=> (state == eeprom_pkg::ST_IDLE) && !sdaOe;
    endproperty
    a_busy_deaf: assert property (p_busy_deaf) else $error("answered while busy");
    property p_mismatch_nack;
        s_devJudge and !devMatch |=> (state == eeprom_pkg::ST_IDLE) && !sdaOe;
    endproperty
    a_mismatch_nack: assert property (p_mismatch_nack) else $error("foreign ack");
    property p_match_ack;
        s_devJudge and devMatch and !busy |=> (state == eeprom_pkg::ST_ACK) && sdaOe;
    endproperty
    a_match_ack: assert property (p_match_ack) else $error("own address not acked");
    property p_page_wrap;
        pushValid && pushReady |=> (addr[8:4] == $past(addr[8:4])) &&
                                   (addr[3:0] == $past(addr[3:0]) + 4'h1);
    endproperty
    a_page_wrap: assert property (p_page_wrap) else $error("page address slip");
    property p_read_incr;
        loadRead |=> (addr == $past(addr) + 9'h001) && (state == eeprom_pkg::ST_SEND);
    endproperty
    a_read_incr: assert property (p_read_incr) else $error("read counter slip");
    property p_nack_quit;
        s_nackFall |=> (state == eeprom_pkg::ST_IDLE) ##1 !sdaOe;
    endproperty
    a_nack_quit: assert property (p_nack_quit) else $error("sent after nack");
    property p_busy_time;
        $rose(busy) |-> (waitCnt == CNT_W'(WRITE_CYCLES - 1));
    endproperty
    a_busy_time: assert property (p_busy_time) else $error("write cycle length");

endmodule : eeprom_serial_slave

// ===== verif/i2c_master_model.sv
`timescale 1ns/1ps
// two-wire bus master; sda has a pull-up, so a released line reads high
module i2c_master_model (
    // bus lines
    output logic scl,
    output logic sdaLow,
    input wire logic sda
);
    // clock stands high between frames, data released
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    // one bit: data changes in clock low, read at mid high
    task automatic bitIo(input logic b, output logic r);
        sdaLow = !b;
        #60ns scl = 1'b1;
        #40ns r = sda;
        #40ns scl = 1'b0;
        #20ns;
    endtask : bitIo
    // start or repeated start: data falls while clock high
    task automatic start();
        sdaLow = 1'b0;
        #60ns scl = 1'b1;
        #80ns sdaLow = 1'b1;
        #80ns scl = 1'b0;
        #20ns;
    endtask : start
    // stop after our release, data rises while clock high
    task automatic stop();
        sdaLow = 1'b1;
        #60ns scl = 1'b1;
        #80ns sdaLow = 1'b0;
        #200ns;
    endtask : stop
    // send a byte msb first, then release for the ninth clock
    task automatic wrByte(input logic [7:0] v, output logic ackd);
        logic r;
        for (int i = 7; i >= 0; i--) bitIo(v[i], r);
        bitIo(1'b1, r);
        ackd = !r;
    endtask : wrByte
    // receive a byte; a nack holds data high through the ninth clock
    task automatic rdByte(input logic ackIt, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitIo(1'b1, r);
            v[i] = r;
        end
        bitIo(!ackIt, r);
    endtask : rdByte
endmodule : i2c_master_model

// ===== verif/eeprom_serial_slave_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module eeprom_serial_slave_tb;
    localparam logic [3:0] DT = 4'h5;  // arbitrary type code
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] cs = 2'b10;  // {high pin, low pin}
    logic scl, sdaLow, sdaOut, sdaOe, writeBusy, a;
    logic [7:0] d;
    logic [7:0] mem [int];  // reference array
    int ptr = 0;  // reference address counter
    int bad_count = 0;
    int checked = 0;
    logic [31:0] seed = 32'h4cf3;
    wire sda;
    // open-drain wire with pull-up
    assign sda = !((sdaOe & !sdaOut) | sdaLow);
    always #10ns sys_clk = !sys_clk;
    eeprom_serial_slave #(.DEV_TYPE(DT), .WRITE_CYCLES(200)) eeprom_serial_slave_inst (
        .sys_clk(sys_clk), .rst(rst), .scl(scl), .sdaIn(sda), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .chipSelectLowPin(cs[0]), .chipSelectHighPin(cs[1]),
        .unusedAddressPin(1'b0), .writeBusy(writeBusy));
    i2c_master_model i2c_master_model_inst (.scl(scl), .sdaLow(sdaLow), .sda(sda));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    function automatic logic [7:0] dev(input logic rw, input logic blk);
        return {DT, cs, blk, rw};
    endfunction : dev
    task automatic finish_test();
        if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    // select with a given slave address byte
    task automatic sel(input logic [7:0] v, input logic exp);
        i2c_master_model_inst.start();
        i2c_master_model_inst.wrByte(v, a);
        `CHK("addrAck", exp, a)
    endtask : sel
    // page write of n random bytes, one busy address try, then wait on writeBusy until done
    task automatic doWrite(input logic [8:0] ad, input int n);
        sel(dev(1'b0, ad[8]), 1'b1);
        i2c_master_model_inst.wrByte(ad[7:0], a);
        for (int i = 0; i < n; i++) begin
            d = rnd();
            i2c_master_model_inst.wrByte(d, a);
            `CHK("dataAck", 1'b1, a)
            ptr = {ad[8:4], 4'(ad[3:0] + i)};  // page wrap
            mem[ptr] = d;
        end
        ptr = (ptr + 1) % 512;
        i2c_master_model_inst.stop();
        #200ns `CHK("writeBusy", 1'b1, writeBusy)
        sel(dev(1'b0, 1'b0), 1'b0);  // busy: no answer at all
        i2c_master_model_inst.stop();
        for (int k = 0; k < 40 && writeBusy !== 1'b0; k++) #1us;
        sel(dev(1'b0, 1'b0), 1'b1);
        i2c_master_model_inst.stop();
    endtask : doWrite
    // read n bytes from the counter, nack on the last
    task automatic rd(input int n);
        for (int i = 0; i < n; i++) begin
            i2c_master_model_inst.rdByte(i < n - 1, d);
            `CHK("readData", mem[ptr], d)
            ptr = (ptr + 1) % 512;
        end
        i2c_master_model_inst.stop();
    endtask : rd
    initial begin
        #1ms bad_count++;
        finish_test();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        #2ns rst = 1'b0;
        repeat (4) @(posedge sys_clk);
        #2ns;  // every bus move then lands just after an edge, clear of sampling
        sel({DT, ~cs, 2'b00}, 1'b0);  // foreign chip select
        sel({DT ^ 4'h1, cs, 2'b00}, 1'b0);  // foreign type
        i2c_master_model_inst.stop();
        doWrite(9'h1f8, 17);  // seventeenth byte wraps onto the first
        sel(dev(1'b1, 1'b0), 1'b1);  // current address read
        rd(1);
        doWrite(9'h000, 1);
        sel(dev(1'b0, 1'b1), 1'b1);  // random read across the top of the array
        i2c_master_model_inst.wrByte(8'hf1, a);
        sel(dev(1'b1, 1'b0), 1'b1);
        ptr = 9'h1f1;
        rd(16);
        finish_test();
    end
endmodule : eeprom_serial_slave_tb
